// ### verilog/serial_rx_pkg.sv
// Purpose: constants and types shared by the serial receiver block
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes: field positions follow the receive status/control layout
package serial_rx_pkg;
  // register byte addresses
  localparam logic [7:0] RX_STAT_CTRL_ADDR = 8'h18;
  localparam logic [7:0] RX_DATA_ADDR = 8'h1C;
  localparam logic [7:0] TX_CTRL_ADDR = 8'h20;
  localparam logic [7:0] BAUD_DIV_ADDR = 8'h24;
  localparam logic [7:0] PERIPH_FLAG_ADDR = 8'h28;
  localparam logic [7:0] PERIPH_EN_ADDR = 8'h2C;
  localparam logic [7:0] TX_DATA_ADDR = 8'h30;
  // receive status/control fields
  localparam int SERIAL_PORT_ON_BIT = 7;
  localparam int NINE_BIT_RX_BIT = 6;
  localparam int SINGLE_RX_BIT = 5;
  localparam int CONT_RX_BIT = 4;
  localparam int ADDR_DETECT_BIT = 3;
  // transmit control fields
  localparam int NINE_BIT_TX_BIT = 6;
  localparam int TX_ON_BIT = 5;
  localparam int SYNC_MODE_BIT = 4;
  localparam int HIGH_BAUD_BIT = 2;
  localparam int TX_NINTH_BIT = 0;
  // flag and enable fields
  localparam int RX_INT_BIT = 5;
  localparam int TX_INT_BIT = 4;
  // reset values
  localparam logic [7:0] BAUD_DIV_RESET = 8'h00;
  // timing
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
  localparam logic [3:0] MID_SAMPLE = 4'h7;
  localparam logic [1:0] LOW_SPEED_EXTRA = 2'h3;
  localparam logic [3:0] RX_LAST_BIT_8 = 4'h7;
  localparam logic [3:0] RX_LAST_BIT_9 = 4'h8;
  localparam logic [3:0] TX_FRAME_8 = 4'hA;
  localparam logic [3:0] TX_FRAME_9 = 4'hB;
  localparam logic [1:0] FIFO_FULL_COUNT = 2'h2;
  localparam logic [1:0] HTRANS_IDLE = 2'h0;

  typedef struct packed {
    logic framing_err;
    logic ninth;
    logic [7:0] data;
  } rx_entry_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
  } bus_req_t;

  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
endpackage : serial_rx_pkg

// ### verilog/async_serial_receiver.sv
// Purpose: asynchronous serial receive path with two-deep FIFO, small transmitter, AHB-Lite registers
// Assumes: MCLK 125 MHz, SYS_RST async active high, one bus master, zero wait states
// Notes: oversampled receive, per-entry status, overrun lock until continuous receive is cycled
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module async_serial_receiver (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic RX_PIN,
  output logic TX_PIN_O,
  output logic TX_PIN_OE,
  output logic SERIAL_PINS_SEL,
  output logic RX_IRQ,
  output logic TX_IRQ
);
  function automatic logic reg_hit(input logic [31:0] a, input logic [7:0] off);
    return a == {24'h000000, off};
  endfunction : reg_hit

  // control registers
  logic serial_port_on_r, nine_bit_rx_sel_r, single_rx_on_r, continuous_rx_on_r, addr_detect_on_r;
  logic overrun_err_flag_r;
  logic nine_bit_tx_sel_r, tx_on_r, sync_mode_r, high_baud_sel_r, tx_ninth_bit_r;
  logic rx_int_enable_r, tx_int_enable_r;
  logic [7:0] baud_divisor_r;

  // bus pipeline
  serial_rx_pkg::bus_req_t dp_r;
  logic bus_acc;
  logic wr_en;
  logic [31:0] wr_addr;
  logic [7:0] wdata;
  assign bus_acc = HSEL & HTRANS[1] & HREADY;
  assign wr_en = dp_r.wr;
  assign wr_addr = {24'h000000, dp_r.addr};
  assign wdata = HWDATA[7:0];

  // pin synchroniser
  logic rx_meta_r, rx_sync_r, rx_line;
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
    end else begin
      rx_meta_r <= RX_PIN;
      rx_sync_r <= rx_meta_r;
    end
  end
  // pin reads as idle while the port does not own it
  assign rx_line = rx_sync_r | ~serial_port_on_r;

  // sixteen-times tick; low speed stretches the divisor by four
  logic [9:0] tick_cnt_r, tick_lim;
  logic tick;
  assign tick_lim = high_baud_sel_r ? {2'h0, baud_divisor_r} : {baud_divisor_r, serial_rx_pkg::LOW_SPEED_EXTRA};
  assign tick = serial_port_on_r & (tick_cnt_r == tick_lim);
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tick_cnt_r <= 10'h000;
    end else if (!serial_port_on_r || tick) begin
      tick_cnt_r <= 10'h000;
    end else begin
      tick_cnt_r <= 10'(tick_cnt_r + 10'h001);
    end
  end

  // receiver
  serial_rx_pkg::rx_state_t rx_st_r;
  logic [3:0] os_cnt_r, bit_idx_r;
  logic [8:0] rx_shift_register_r;
  logic rx_run, frame_done, addr_skip, push, pop, overrun;
  serial_rx_pkg::rx_entry_t frame_in;
  assign rx_run = serial_port_on_r & (continuous_rx_on_r | (sync_mode_r & single_rx_on_r));
  assign frame_done = rx_run & tick & (rx_st_r == serial_rx_pkg::RX_STOP) & (os_cnt_r == serial_rx_pkg::OVERSAMPLE_LAST);

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rx_st_r <= serial_rx_pkg::RX_IDLE;
      os_cnt_r <= 4'h0;
      bit_idx_r <= 4'h0;
      rx_shift_register_r <= 9'h000;
    end else if (!rx_run) begin
      rx_st_r <= serial_rx_pkg::RX_IDLE;
      os_cnt_r <= 4'h0;
    end else if (tick) begin
      case (rx_st_r)
        serial_rx_pkg::RX_IDLE: begin
          os_cnt_r <= 4'h0;
          if (!rx_line) begin
            rx_st_r <= serial_rx_pkg::RX_START;
          end
        end
        serial_rx_pkg::RX_START: begin
          if (os_cnt_r == serial_rx_pkg::MID_SAMPLE) begin
            os_cnt_r <= 4'h0;
            bit_idx_r <= 4'h0;
            // a high line at mid start was a glitch
            rx_st_r <= rx_line ? serial_rx_pkg::RX_IDLE : serial_rx_pkg::RX_DATA;
          end else begin
            os_cnt_r <= 4'(os_cnt_r + 4'h1);
          end
        end
        serial_rx_pkg::RX_DATA: begin
          if (os_cnt_r == serial_rx_pkg::OVERSAMPLE_LAST) begin
            os_cnt_r <= 4'h0;
            rx_shift_register_r <= {rx_line, rx_shift_register_r[8:1]};
            if (bit_idx_r == (nine_bit_rx_sel_r ? serial_rx_pkg::RX_LAST_BIT_9 : serial_rx_pkg::RX_LAST_BIT_8)) begin
              rx_st_r <= serial_rx_pkg::RX_STOP;
            end else begin
              bit_idx_r <= 4'(bit_idx_r + 4'h1);
            end
          end else begin
            os_cnt_r <= 4'(os_cnt_r + 4'h1);
          end
        end
        serial_rx_pkg::RX_STOP: begin
          if (os_cnt_r == serial_rx_pkg::OVERSAMPLE_LAST) begin
            os_cnt_r <= 4'h0;
            rx_st_r <= serial_rx_pkg::RX_IDLE;
          end else begin
            os_cnt_r <= 4'(os_cnt_r + 4'h1);
          end
        end
        default: begin
          rx_st_r <= serial_rx_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // eight-bit frames end up in the upper bits of the shifter
  always_comb begin
    frame_in.framing_err = ~rx_line;
    frame_in.ninth = nine_bit_rx_sel_r & rx_shift_register_r[8];
    frame_in.data = nine_bit_rx_sel_r ? rx_shift_register_r[7:0] : rx_shift_register_r[8:1];
  end

  // two-entry receive FIFO
  serial_rx_pkg::rx_entry_t rx_data_fifo [2];
  logic wp_r, rp_r;
  logic [1:0] cnt_r;
  serial_rx_pkg::rx_entry_t head;
  logic rx_int_flag;
  assign head = rx_data_fifo[rp_r];
  assign rx_int_flag = cnt_r != 2'h0;
  assign addr_skip = nine_bit_rx_sel_r & addr_detect_on_r & ~frame_in.ninth;
  assign push = frame_done & ~overrun_err_flag_r & ~addr_skip & (cnt_r != serial_rx_pkg::FIFO_FULL_COUNT);
  assign overrun = frame_done & ~overrun_err_flag_r & ~addr_skip & (cnt_r == serial_rx_pkg::FIFO_FULL_COUNT);
  assign pop = bus_acc & ~HWRITE & reg_hit(HADDR, serial_rx_pkg::RX_DATA_ADDR) & rx_int_flag;

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
      rx_data_fifo[0] <= '0;
      rx_data_fifo[1] <= '0;
    end else begin
      if (push) begin
        rx_data_fifo[wp_r] <= frame_in;
        wp_r <= ~wp_r;
      end
      if (pop) begin
        rp_r <= ~rp_r;
      end
      case ({push, pop})
        2'b10: cnt_r <= 2'(cnt_r + 2'h1);
        2'b01: cnt_r <= 2'(cnt_r - 2'h1);
        default: cnt_r <= cnt_r;
      endcase
    end
  end

  // a flag set by a new overrun wins over the clear
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      overrun_err_flag_r <= 1'b0;
    end else if (overrun) begin
      overrun_err_flag_r <= 1'b1;
    end else if (!continuous_rx_on_r) begin
      overrun_err_flag_r <= 1'b0;
    end
  end

  // transmitter
  logic [8:0] tx_buf_r;
  logic tx_buf_full_r, tx_busy_r, tx_load, tx_int_flag, tx_wr;
  logic [10:0] tx_sh_r;
  logic [3:0] tx_bits_r, tx_os_r;
  assign tx_wr = wr_en & reg_hit(wr_addr, serial_rx_pkg::TX_DATA_ADDR);
  assign tx_load = ~tx_busy_r & tx_buf_full_r & tx_on_r & serial_port_on_r;
  assign tx_int_flag = tx_on_r & ~tx_buf_full_r;

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tx_buf_r <= 9'h000;
      tx_buf_full_r <= 1'b0;
    end else if (!tx_on_r) begin
      tx_buf_full_r <= 1'b0;
    end else if (tx_wr) begin
      tx_buf_r <= {tx_ninth_bit_r, wdata};
      tx_buf_full_r <= 1'b1;
    end else if (tx_load) begin
      tx_buf_full_r <= 1'b0;
    end
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tx_busy_r <= 1'b0;
      tx_sh_r <= 11'h7FF;
      tx_bits_r <= 4'h0;
      tx_os_r <= 4'h0;
    end else if (!serial_port_on_r || !tx_on_r) begin
      tx_busy_r <= 1'b0;
      tx_sh_r <= 11'h7FF;
    end else if (tx_load) begin
      tx_busy_r <= 1'b1;
      tx_os_r <= 4'h0;
      tx_sh_r <= nine_bit_tx_sel_r ? {1'b1, tx_buf_r, 1'b0} : {2'h3, tx_buf_r[7:0], 1'b0};
      tx_bits_r <= nine_bit_tx_sel_r ? serial_rx_pkg::TX_FRAME_9 : serial_rx_pkg::TX_FRAME_8;
    end else if (tx_busy_r && tick) begin
      tx_os_r <= 4'(tx_os_r + 4'h1);
      if (tx_os_r == serial_rx_pkg::OVERSAMPLE_LAST) begin
        tx_sh_r <= {1'b1, tx_sh_r[10:1]};
        tx_bits_r <= 4'(tx_bits_r - 4'h1);
        tx_busy_r <= tx_bits_r != 4'h1;
      end
    end
  end

  // register writes land in the data phase
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      dp_r <= '0;
    end else if (HREADY) begin
      dp_r.addr <= (HADDR[31:8] == 24'h000000) ? HADDR[7:0] : 8'hFF;
      dp_r.wr <= bus_acc & HWRITE;
    end
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      serial_port_on_r <= 1'b0;
      nine_bit_rx_sel_r <= 1'b0;
      single_rx_on_r <= 1'b0;
      continuous_rx_on_r <= 1'b0;
      addr_detect_on_r <= 1'b0;
    end else if (wr_en && reg_hit(wr_addr, serial_rx_pkg::RX_STAT_CTRL_ADDR)) begin
      serial_port_on_r <= wdata[serial_rx_pkg::SERIAL_PORT_ON_BIT];
      nine_bit_rx_sel_r <= wdata[serial_rx_pkg::NINE_BIT_RX_BIT];
      single_rx_on_r <= wdata[serial_rx_pkg::SINGLE_RX_BIT];
      continuous_rx_on_r <= wdata[serial_rx_pkg::CONT_RX_BIT];
      addr_detect_on_r <= wdata[serial_rx_pkg::ADDR_DETECT_BIT];
    end else if (frame_done && sync_mode_r) begin
      single_rx_on_r <= 1'b0;
    end
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      nine_bit_tx_sel_r <= 1'b0;
      tx_on_r <= 1'b0;
      sync_mode_r <= 1'b0;
      high_baud_sel_r <= 1'b0;
      tx_ninth_bit_r <= 1'b0;
    end else if (wr_en && reg_hit(wr_addr, serial_rx_pkg::TX_CTRL_ADDR)) begin
      nine_bit_tx_sel_r <= wdata[serial_rx_pkg::NINE_BIT_TX_BIT];
      tx_on_r <= wdata[serial_rx_pkg::TX_ON_BIT];
      sync_mode_r <= wdata[serial_rx_pkg::SYNC_MODE_BIT];
      high_baud_sel_r <= wdata[serial_rx_pkg::HIGH_BAUD_BIT];
      tx_ninth_bit_r <= wdata[serial_rx_pkg::TX_NINTH_BIT];
    end
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      baud_divisor_r <= serial_rx_pkg::BAUD_DIV_RESET;
      rx_int_enable_r <= 1'b0;
      tx_int_enable_r <= 1'b0;
    end else if (wr_en && reg_hit(wr_addr, serial_rx_pkg::BAUD_DIV_ADDR)) begin
      baud_divisor_r <= wdata;
    end else if (wr_en && reg_hit(wr_addr, serial_rx_pkg::PERIPH_EN_ADDR)) begin
      rx_int_enable_r <= wdata[serial_rx_pkg::RX_INT_BIT];
      tx_int_enable_r <= wdata[serial_rx_pkg::TX_INT_BIT];
    end
  end

  // read data is latched at the address phase so it is ready in the data phase
  logic [7:0] rd_nxt;
  always_comb begin
    rd_nxt = 8'h00;
    if (reg_hit(HADDR, serial_rx_pkg::RX_STAT_CTRL_ADDR)) begin
      rd_nxt = {serial_port_on_r, nine_bit_rx_sel_r, single_rx_on_r, continuous_rx_on_r, addr_detect_on_r,
                head.framing_err & rx_int_flag, overrun_err_flag_r, head.ninth & rx_int_flag};
    end else if (reg_hit(HADDR, serial_rx_pkg::RX_DATA_ADDR)) begin
      rd_nxt = rx_int_flag ? head.data : 8'h00;
    end else if (reg_hit(HADDR, serial_rx_pkg::TX_CTRL_ADDR)) begin
      rd_nxt = {1'b0, nine_bit_tx_sel_r, tx_on_r, sync_mode_r, 1'b0, high_baud_sel_r, ~tx_busy_r, tx_ninth_bit_r};
    end else if (reg_hit(HADDR, serial_rx_pkg::BAUD_DIV_ADDR)) begin
      rd_nxt = baud_divisor_r;
    end else if (reg_hit(HADDR, serial_rx_pkg::PERIPH_FLAG_ADDR)) begin
      rd_nxt = {2'h0, rx_int_flag, tx_int_flag, 4'h0};
    end else if (reg_hit(HADDR, serial_rx_pkg::PERIPH_EN_ADDR)) begin
      rd_nxt = {2'h0, rx_int_enable_r, tx_int_enable_r, 4'h0};
    end else if (reg_hit(HADDR, serial_rx_pkg::TX_DATA_ADDR)) begin
      rd_nxt = tx_buf_r[7:0];
    end
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      HRDATA <= 32'h00000000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      if (bus_acc && !HWRITE) begin
        HRDATA <= {24'h000000, rd_nxt};
      end
    end
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      TX_PIN_O <= 1'b1;
      TX_PIN_OE <= 1'b0;
      SERIAL_PINS_SEL <= 1'b0;
      RX_IRQ <= 1'b0;
      TX_IRQ <= 1'b0;
    end else begin
      TX_PIN_O <= tx_sh_r[0];
      TX_PIN_OE <= serial_port_on_r;
      SERIAL_PINS_SEL <= serial_port_on_r;
      RX_IRQ <= rx_int_flag & rx_int_enable_r;
      TX_IRQ <= tx_int_flag & tx_int_enable_r;
    end
  end

  default clocking @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  chk_pin_handover: assert property (
    serial_port_on_r |=> (SERIAL_PINS_SEL && TX_PIN_OE)) else $error("pins not handed to serial port");
  chk_nine_bit_len: assert property (
    frame_done |-> bit_idx_r == (nine_bit_rx_sel_r ? 4'h8 : 4'h7)) else $error("wrong data bit count");
  chk_rx_gate_off: assert property (
    !rx_run |=> (rx_st_r == serial_rx_pkg::RX_IDLE) && !frame_done) else $error("receiver ran while disabled");
  chk_single_clear: assert property (
    (frame_done && sync_mode_r && !wr_en) |=> !single_rx_on_r) else $error("single receive not cleared");
  chk_addr_drop: assert property (
    (frame_done && addr_skip) |=> cnt_r <= $past(cnt_r)) else $error("address frame kept");
  chk_bit_period: assert property (
    (rx_run && tick && rx_st_r == serial_rx_pkg::RX_DATA && os_cnt_r != 4'hF) |=> rx_st_r == serial_rx_pkg::RX_DATA)
    else $error("bit ended early");
  chk_push_irq: assert property (
    (push && !pop) ##1 rx_int_enable_r |=> RX_IRQ) else $error("no interrupt after frame");
  chk_flag_empty: assert property (
    (cnt_r == 2'h0) |=> !RX_IRQ) else $error("flag set with empty fifo");
  chk_irq_mask: assert property (
    !rx_int_enable_r |=> !RX_IRQ) else $error("masked interrupt seen");
  chk_fifo_depth: assert property (
    cnt_r <= 2'h2) else $error("fifo over depth");
  chk_overrun_set: assert property (
    overrun |=> overrun_err_flag_r && cnt_r == 2'(2'h2 - {1'b0, $past(pop)})) else $error("overrun not flagged");
  chk_overrun_block: assert property (
    overrun_err_flag_r |-> !push) else $error("load while overrun");
  chk_overrun_clear: assert property (
    (!continuous_rx_on_r && !overrun) |=> !overrun_err_flag_r) else $error("overrun not cleared");
  chk_tx_flag_on: assert property (
    ($rose(tx_on_r) && !tx_wr) |-> tx_int_flag) else $error("transmit flag not raised");
endmodule : async_serial_receiver
`default_nettype wire

// ### sim/serial_tx_model.sv
// Purpose: behavioural far-end serial transmitter driving the receive line
// Assumes: bit time is a whole number of clocks, set by BIT_CYC
// Notes: line idles high between frames; gap sets how promptly a frame follows
`timescale 1ns/1ps
`default_nettype none
module serial_tx_model #(
  parameter int BIT_CYC = 16
) (
  input wire logic clk,
  output logic line
);
  initial line = 1'b1;

  // gap 0 sends back to back, straight after the previous stop bit
  task automatic send(input logic [8:0] d, input logic nine, input logic stop_v, input int gap);
    logic [10:0] fr;
    int n;
    n = nine ? 11 : 10;
    fr = nine ? {stop_v, d, 1'b0} : {1'b1, stop_v, d[7:0], 1'b0};
    repeat (gap) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      line <= fr[i];
      repeat (BIT_CYC) @(posedge clk);
    end
    // a low stop bit must not leave the line looking like a new start
    if (line !== 1'b1) begin
      line <= 1'b1;
      @(posedge clk);
    end
  endtask : send
endmodule : serial_tx_model
`default_nettype wire

// ### sim/tb.sv
// Purpose: self-checking bench for the serial receiver block
// Assumes: divisor 0 with high baud select, so one bit lasts 16 clocks
// Notes: each read queues its expected word; a monitor compares in the data phase
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [7:0] A_ST = serial_rx_pkg::RX_STAT_CTRL_ADDR;
  localparam logic [7:0] A_DAT = serial_rx_pkg::RX_DATA_ADDR;
  localparam logic [7:0] A_TXC = serial_rx_pkg::TX_CTRL_ADDR;
  localparam logic [7:0] A_FLG = serial_rx_pkg::PERIPH_FLAG_ADDR;
  localparam logic [7:0] A_EN = serial_rx_pkg::PERIPH_EN_ADDR;
  localparam logic [7:0] A_DIV = serial_rx_pkg::BAUD_DIV_ADDR;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, rx_line, tx_o, tx_oe, pins_sel, rx_irq, tx_irq;
  logic rd_pend = 1'b0;
  logic [31:0] exp_q[$];
  logic [7:0] b [0:3];
  logic [9:0] txf;
  int fail_count = 0;
  int checked = 0;
  int cyc = 0;
  int seed = 87902;

  always #4 mclk = ~mclk;

  async_serial_receiver dut (.MCLK(mclk), .SYS_RST(sys_rst), .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .RX_PIN(rx_line), .TX_PIN_O(tx_o), .TX_PIN_OE(tx_oe),
    .SERIAL_PINS_SEL(pins_sel), .RX_IRQ(rx_irq), .TX_IRQ(tx_irq));

  serial_tx_model #(.BIT_CYC(16)) far (.clk(mclk), .line(rx_line));

  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one single transfer: address phase held until ready, then data phase
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    htrans <= serial_rx_pkg::HTRANS_IDLE;
    hwdata <= w ? d : 32'h0;
    rd_pend <= ~w;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rd_pend <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(a, 1'b0, 32'h0);
  endtask : rd

  // registered level outputs need a couple of edges to follow a write
  task automatic settle;
    repeat (2) @(posedge mclk);
    #1;
  endtask : settle

  always @(posedge mclk) begin
    if (rd_pend && hreadyout) begin
      chk(hrdata, exp_q.pop_front());
    end
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      stop_test();
    end
  end

  initial begin
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 4; i++) b[i] = 8'($random(seed));
    rd(A_ST, 32'h0);
    rd(A_FLG, 32'h0);
    rd(8'h34, 32'h0);
    chk({31'h0, pins_sel}, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    wr(A_DIV, {24'h0, b[2]});
    rd(A_DIV, {24'h0, b[2]});
    wr(A_DIV, 32'h0);
    wr(A_TXC, 32'h4);
    rd(A_TXC, 32'h6);
    wr(A_EN, 32'h20);
    wr(A_ST, 32'h90);
    settle();
    chk({31'h0, pins_sel}, 32'h1);
    rd(A_ST, 32'h90);
    far.send({1'b0, b[0]}, 1'b0, 1'b1, 3);
    far.send({1'b0, b[1]}, 1'b0, 1'b0, 0);
    settle();
    chk({31'h0, rx_irq}, 32'h1);
    rd(A_FLG, 32'h20);
    rd(A_ST, 32'h90);
    rd(A_DAT, {24'h0, b[0]});
    rd(A_ST, 32'h94);
    wr(A_EN, 32'h0);
    settle();
    chk({31'h0, rx_irq}, 32'h0);
    wr(A_FLG, 32'h30);
    rd(A_FLG, 32'h20);
    rd(A_DAT, {24'h0, b[1]});
    rd(A_FLG, 32'h0);
    rd(A_ST, 32'h90);
    // three frames with no reads between them
    far.send({1'b0, b[0]}, 1'b0, 1'b1, 2);
    far.send({1'b0, b[1]}, 1'b0, 1'b1, 0);
    far.send({1'b0, b[2]}, 1'b0, 1'b1, 0);
    settle();
    rd(A_ST, 32'h92);
    rd(A_DAT, {24'h0, b[0]});
    rd(A_DAT, {24'h0, b[1]});
    far.send({1'b0, b[3]}, 1'b0, 1'b1, 2);
    settle();
    rd(A_FLG, 32'h0);
    wr(A_ST, 32'h80);
    far.send({1'b0, b[3]}, 1'b0, 1'b1, 2);
    settle();
    rd(A_FLG, 32'h0);
    rd(A_ST, 32'h80);
    wr(A_ST, 32'h90);
    far.send({1'b0, b[2]}, 1'b0, 1'b1, 2);
    settle();
    rd(A_DAT, {24'h0, b[2]});
    wr(A_ST, 32'hD8);
    far.send(9'h0A5, 1'b1, 1'b1, 2);
    far.send({1'b1, b[1]}, 1'b1, 1'b1, 0);
    settle();
    rd(A_ST, 32'hD9);
    rd(A_DAT, {24'h0, b[1]});
    rd(A_FLG, 32'h0);
    wr(A_ST, 32'hD0);
    far.send({1'b0, b[0]}, 1'b1, 1'b1, 2);
    settle();
    rd(A_ST, 32'hD0);
    rd(A_DAT, {24'h0, b[0]});
    // sync mode: single receive takes one frame, then clears itself
    wr(A_ST, 32'hA0);
    wr(A_TXC, 32'h14);
    far.send({1'b0, b[2]}, 1'b0, 1'b1, 2);
    settle();
    rd(A_ST, 32'h80);
    rd(A_DAT, {24'h0, b[2]});
    far.send({1'b0, b[3]}, 1'b0, 1'b1, 2);
    settle();
    rd(A_FLG, 32'h0);
    wr(A_EN, 32'h10);
    wr(A_TXC, 32'h24);
    settle();
    chk({31'h0, tx_irq}, 32'h1);
    chk({31'h0, tx_oe}, 32'h1);
    rd(A_FLG, 32'h10);
    wr(serial_rx_pkg::TX_DATA_ADDR, {24'h0, b[3]});
    // look past the edge so the registered pin has settled
    for (int k = 0; k < 300 && tx_o !== 1'b0; k++) begin
      @(posedge mclk);
      #1;
    end
    repeat (8) @(posedge mclk);
    for (int i = 0; i < 10; i++) begin
      txf[i] = tx_o;
      repeat (16) @(posedge mclk);
    end
    chk({22'h0, txf}, {22'h0, 1'b1, b[3], 1'b0});
    stop_test();
  end
endmodule : tb
`default_nettype wire
